/* hw/rotate_pkg.sv */
package rotate_pkg;

	// ==========================================
	// Widths
	localparam int unsigned DATA_W     = 16;
	localparam int unsigned REG_IDX_W  = 4;

	// ==========================================
	// Pointer step sizes
	localparam logic [15:0] STEP_WORD  = 16'h0002;
	localparam logic [15:0] STEP_BYTE  = 16'h0001;

	// ==========================================
	// Reset values
	localparam logic [15:0] RESULT_RST = 16'h0000;
	localparam logic        FLAG_RST   = 1'b0;

	// ==========================================
	// Operations
	typedef enum logic [1:0] {
		rotate_right_through_carry = 2'b00,
		rotate_right_no_carry      = 2'b01,
		rotate_left_through_carry  = 2'b11,
		rotate_left_no_carry       = 2'b10
	} rot_op_e;

	// Addressing modes of one operand
	typedef enum logic [2:0] {
		mode_direct    = 3'b000,
		mode_indirect  = 3'b001,
		mode_post_inc  = 3'b011,
		mode_post_dec  = 3'b010,
		mode_pre_inc   = 3'b110,
		mode_pre_dec   = 3'b111
	} addr_mode_e;

	typedef struct packed {
		rot_op_e           op;
		logic              byte_mode;
		addr_mode_e        src_mode;
		logic [3:0]        source_operand_reg;
		addr_mode_e        dst_mode;
		logic [3:0]        dest_operand_reg;
	} rot_cmd_s;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
	} rot_flags_s;

endpackage : rotate_pkg

/* hw/rotate_unit.sv */
// Overview of operation
// RQ1: Rotate right through carry, carry as extra bit
// RQ2: Old carry goes to result MSB
// RQ3: Carry takes source LSB afterward
// RQ4: Rotate right no carry: LSB to MSB
// RQ5: No-carry rotates leave carry unchanged
// RQ6: Operands direct or indirect via working register
// RQ7: Word post-increment advances pointer by two
// RQ8: N is result MSB, Z when zero
`timescale 1ns/1ps

module rotate_unit
	import rotate_pkg::*;
(
	input  wire logic        clock_i,
	input  wire logic        nrst_i,
	input  wire logic        start_i,
	input  rot_cmd_s         cmd_i,
	input  wire logic [15:0] src_ptr_i,
	input  wire logic [15:0] src_data_i,
	input  wire logic [15:0] dst_ptr_i,
	input  wire logic        carry_i,
	output logic      [15:0] src_addr_o,
	output logic      [15:0] src_ptr_new_o,
	output logic             src_ptr_we_o,
	output logic      [15:0] dst_addr_o,
	output logic      [15:0] dst_ptr_new_o,
	output logic             dst_ptr_we_o,
	output logic             dst_is_mem_o,
	output logic      [15:0] result_o,
	output logic             result_valid_o,
	output rot_flags_s       flags_o
);

	// ==========================================
	// Helpers
	function automatic logic [15:0] ptr_step(input logic byte_mode);
		ptr_step = byte_mode ? STEP_BYTE : STEP_WORD;
	endfunction : ptr_step

	function automatic logic [15:0] eff_addr(input addr_mode_e m, input logic [15:0] p,
		input logic [15:0] s);
		case (m)
			mode_pre_inc: eff_addr = p + s;
			mode_pre_dec: eff_addr = p - s;
			default:      eff_addr = p;
		endcase
	endfunction : eff_addr

	function automatic logic [15:0] new_ptr(input addr_mode_e m, input logic [15:0] p,
		input logic [15:0] s);
		case (m)
			mode_post_inc, mode_pre_inc: new_ptr = p + s;
			mode_post_dec, mode_pre_dec: new_ptr = p - s;
			default:                     new_ptr = p;
		endcase
	endfunction : new_ptr

	// ==========================================
	// Operand addressing
	wire logic [15:0] step = ptr_step(cmd_i.byte_mode);
	wire logic        src_upd = (cmd_i.src_mode != mode_direct) && (cmd_i.src_mode != mode_indirect);
	wire logic        dst_upd = (cmd_i.dst_mode != mode_direct) && (cmd_i.dst_mode != mode_indirect);
	wire logic [15:0] next_src_addr = eff_addr(cmd_i.src_mode, src_ptr_i, step); // [RQ6]
	wire logic [15:0] next_dst_addr = eff_addr(cmd_i.dst_mode, dst_ptr_i, step); // [RQ6]
	wire logic [15:0] next_src_ptr  = new_ptr(cmd_i.src_mode, src_ptr_i, step);  // [RQ7]
	wire logic [15:0] next_dst_ptr  = new_ptr(cmd_i.dst_mode, dst_ptr_i, step);

	// Address goes out combinationally so fetch logic can read in this cycle
	assign src_addr_o = next_src_addr;

	// ==========================================
	// Rotate datapath; byte mode keeps upper byte of source
	wire logic [7:0]  b = src_data_i[7:0];
	wire logic [15:0] w = src_data_i;
	logic      [15:0] next_result;
	logic             next_c;

	always_comb begin
		next_result = w;
		next_c      = carry_i; // [RQ5]
		case (cmd_i.op)
			rotate_right_through_carry: begin
				if (cmd_i.byte_mode) begin
					next_result = {w[15:8], carry_i, b[7:1]}; // [RQ1] [RQ2]
					next_c      = b[0];                      // [RQ3]
				end else begin
					next_result = {carry_i, w[15:1]};        // [RQ1] [RQ2]
					next_c      = w[0];                      // [RQ3]
				end
			end
			rotate_right_no_carry: begin
				if (cmd_i.byte_mode)
					next_result = {w[15:8], b[0], b[7:1]};   // [RQ4]
				else
					next_result = {w[0], w[15:1]};           // [RQ4]
			end
			rotate_left_through_carry: begin
				if (cmd_i.byte_mode) begin
					next_result = {w[15:8], b[6:0], carry_i};
					next_c      = b[7];
				end else begin
					next_result = {w[14:0], carry_i};
					next_c      = w[15];
				end
			end
			rotate_left_no_carry: begin
				if (cmd_i.byte_mode)
					next_result = {w[15:8], b[6:0], b[7]};
				else
					next_result = {w[14:0], w[15]};
			end
			default: begin
				next_result = w;
			end
		endcase
	end

	wire logic next_n = cmd_i.byte_mode ? next_result[7] : next_result[15];        // [RQ8]
	wire logic next_z = cmd_i.byte_mode ? (next_result[7:0] == 8'h00)
		: (next_result == 16'h0000);                                                 // [RQ8]

	// ==========================================
	// Result register
	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i) begin
			result_o       <= RESULT_RST;
			result_valid_o <= 1'b0;
			flags_o        <= '{n: FLAG_RST, z: FLAG_RST, c: FLAG_RST};
			dst_addr_o     <= RESULT_RST;
			dst_is_mem_o   <= 1'b0;
			src_ptr_new_o  <= RESULT_RST;
			src_ptr_we_o   <= 1'b0;
			dst_ptr_new_o  <= RESULT_RST;
			dst_ptr_we_o   <= 1'b0;
		end else begin
			result_valid_o <= start_i;
			src_ptr_we_o   <= start_i && src_upd;
			dst_ptr_we_o   <= start_i && dst_upd;
			if (start_i) begin
				result_o      <= next_result;
				flags_o       <= '{n: next_n, z: next_z, c: next_c};
				dst_addr_o    <= next_dst_addr;
				dst_is_mem_o  <= (cmd_i.dst_mode != mode_direct);
				src_ptr_new_o <= next_src_ptr;
				dst_ptr_new_o <= next_dst_ptr;
			end
		end
	end

	// ==========================================
	// Checks
	sequence s_word_rrc;
		start_i && cmd_i.op == rotate_right_through_carry && !cmd_i.byte_mode;
	endsequence

	sequence s_byte_rrc;
		start_i && cmd_i.op == rotate_right_through_carry && cmd_i.byte_mode;
	endsequence

	sequence s_word_rotate_right_no_carry;
		start_i && cmd_i.op == rotate_right_no_carry && !cmd_i.byte_mode;
	endsequence

	sequence s_byte_rotate_right_no_carry;
		start_i && cmd_i.op == rotate_right_no_carry && cmd_i.byte_mode;
	endsequence

	sequence s_word_post_inc;
		start_i && cmd_i.src_mode == mode_post_inc && !cmd_i.byte_mode;
	endsequence

	// Rotate right through carry
	AST_RRC_RESULT: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ1]
		s_word_rrc |=> result_o == {$past(carry_i), $past(src_data_i[15:1])})
		else $error("rotate right through carry result wrong");
	AST_RRC_MSB: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ2]
		s_word_rrc |=> result_o[15] == $past(carry_i))
		else $error("old carry not in result msb");
	AST_RRC_BYTE: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ2]
		s_byte_rrc |=> result_o[7:0] == {$past(carry_i), $past(src_data_i[7:1])})
		else $error("byte rotate right through carry result wrong");
	AST_RRC_CARRY: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ3]
		start_i && cmd_i.op == rotate_right_through_carry
		|=> flags_o.c == $past(src_data_i[0]))
		else $error("carry not loaded from source lsb");

	// Rotate right without carry; carry kept by both no-carry rotates
	AST_ROTATE_RIGHT_NO_CARRY_RESULT: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ4]
		s_word_rotate_right_no_carry |=> result_o == {$past(src_data_i[0]), $past(src_data_i[15:1])})
		else $error("rotate right no carry result wrong");
	AST_ROTATE_RIGHT_NO_CARRY_BYTE: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ4]
		s_byte_rotate_right_no_carry |=> result_o[7:0] == {$past(src_data_i[0]), $past(src_data_i[7:1])})
		else $error("byte rotate right no carry result wrong");
	AST_NC_KEEP_C: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ5]
		start_i && cmd_i.op inside {rotate_right_no_carry, rotate_left_no_carry}
		|=> flags_o.c == $past(carry_i))
		else $error("no-carry rotate changed carry");

	// Operand addressing; post modes must fetch through the old pointer
	AST_DST_MEM: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ6]
		start_i |=> dst_is_mem_o == ($past(cmd_i.dst_mode) != mode_direct))
		else $error("destination kind wrong");
	AST_SRC_OLD_ADDR: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ6]
		start_i && (cmd_i.src_mode == mode_direct || cmd_i.src_mode == mode_indirect
		|| cmd_i.src_mode == mode_post_inc || cmd_i.src_mode == mode_post_dec)
		|-> src_addr_o == src_ptr_i)
		else $error("source address not the pointer itself");
	AST_POST_INC: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ7]
		s_word_post_inc |=> src_ptr_we_o && src_ptr_new_o == $past(src_ptr_i) + 16'h0002)
		else $error("word post-increment not by two");
	AST_NO_STRAY_WE: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ7]
		!start_i |=> !src_ptr_we_o && !dst_ptr_we_o && !result_valid_o)
		else $error("write-back strobe without an instruction");

	// Flags
	AST_FLAGS_NZ: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ8]
		result_valid_o && !$past(cmd_i.byte_mode)
		|-> flags_o.n == result_o[15] && flags_o.z == (result_o == 16'h0000))
		else $error("negative or zero flag wrong");
	AST_FLAGS_NZ_BYTE: assert property (@(posedge clock_i) disable iff (!nrst_i) // [RQ8]
		result_valid_o && $past(cmd_i.byte_mode)
		|-> flags_o.n == result_o[7] && flags_o.z == (result_o[7:0] == 8'h00))
		else $error("byte negative or zero flag wrong");

endmodule : rotate_unit

/* tb/status_carry_model.sv */
`timescale 1ns/1ps

// ==========================================
// Status carry held by the core
module status_carry_model (
	input  wire logic clock_i,
	input  wire logic nrst_i,
	input  wire logic wb_i,
	input  wire logic c_i,
	input  wire logic preset_i,
	input  wire logic preset_c_i,
	output logic      carry_o
);
	logic c;

	// Preset overrides so the bench can pick any carry before an op
	assign carry_o = preset_i ? preset_c_i : c;

	always_ff @(posedge clock_i or negedge nrst_i) begin
		if (!nrst_i)
			c <= 1'b0;
		else if (wb_i)
			c <= c_i;
	end
endmodule : status_carry_model

/* tb/test_rotate_unit.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin num_errors++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module test_rotate_unit
	import rotate_pkg::*;
;
	logic        clk, nrst, start, pre, pre_c, carry, valid, sp_we, dp_we, d_mem;
	logic [15:0] sptr, sdata, dptr, res, sp_new, dp_new, s_addr, d_addr;
	rot_cmd_s    cmd;
	rot_flags_s  flg;
	int          num_errors, n_tests;
	logic        cexp;

	// ==========================================
	// Design and core model
	rotate_unit dut (.clock_i(clk), .nrst_i(nrst), .start_i(start), .cmd_i(cmd),
		.src_ptr_i(sptr), .src_data_i(sdata), .dst_ptr_i(dptr), .carry_i(carry),
		.src_addr_o(s_addr), .src_ptr_new_o(sp_new), .src_ptr_we_o(sp_we), .dst_addr_o(d_addr),
		.dst_ptr_new_o(dp_new), .dst_ptr_we_o(dp_we), .dst_is_mem_o(d_mem), .result_o(res),
		.result_valid_o(valid), .flags_o(flg));
	status_carry_model core (.clock_i(clk), .nrst_i(nrst), .wb_i(valid), .c_i(flg.c),
		.preset_i(pre), .preset_c_i(pre_c), .carry_o(carry));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ==========================================
	// Expected values
	function automatic logic [16:0] rot(input rot_op_e o, input logic b,
		input logic [15:0] s, input logic c);
		logic [15:0] r;
		logic [7:0]  lo;
		logic        co;
		co = c;
		r  = s;
		lo = s[7:0];
		case (o)
			rotate_right_through_carry: if (b) {lo, co} = {c, s[7:0]}; else {r, co} = {c, s};
			rotate_right_no_carry:      if (b) lo = {s[0], s[7:1]}; else r = {s[0], s[15:1]};
			rotate_left_through_carry:  if (b) {co, lo} = {s[7:0], c}; else {co, r} = {s, c};
			default:                    if (b) lo = {s[6:0], s[7]}; else r = {s[14:0], s[15]};
		endcase
		if (b)
			r = {s[15:8], lo};
		return {co, r};
	endfunction : rot

	// Upper half: effective address; lower half: pointer written back
	function automatic logic [31:0] addr_exp(input addr_mode_e m, input logic [15:0] p,
		input logic [15:0] st);
		case (m)
			mode_pre_inc:  return {p + st, p + st};
			mode_pre_dec:  return {p - st, p - st};
			mode_post_inc: return {p, p + st};
			mode_post_dec: return {p, p - st};
			default:       return {p, p};
		endcase
	endfunction : addr_exp

	// Only legal mode codes reach the design
	function automatic addr_mode_e pick_mode(input logic [2:0] k);
		case (k)
			3'h1:    return mode_indirect;
			3'h2:    return mode_post_inc;
			3'h3:    return mode_post_dec;
			3'h4:    return mode_pre_inc;
			3'h5:    return mode_pre_dec;
			default: return mode_direct;
		endcase
	endfunction : pick_mode

	// ==========================================
	// One rotate, checked when its answer stands
	task automatic run(input rot_op_e o, input logic b, input addr_mode_e m, input addr_mode_e dm,
		input logic [15:0] d, input logic [15:0] p, input logic fw, input logic fc);
		logic [16:0] e;
		logic [15:0] st;
		logic [15:0] q;
		logic [31:0] sa;
		logic [31:0] da;
		q  = 16'($urandom);
		if (fw)
			cexp = fc;
		e  = rot(o, b, d, cexp);
		st = b ? STEP_BYTE : STEP_WORD;
		sa = addr_exp(m, p, st);
		da = addr_exp(dm, q, st);
		cmd = '{o, b, m, 4'h2, dm, 4'h8};
		sdata = d;
		sptr = p;
		dptr = q;
		pre = fw;
		pre_c = fc;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		pre = 1'b0;
		`CHK(valid, 1'b1)
		`CHK(res, e[15:0])
		`CHK(flg.c, e[16])
		`CHK({flg.n, flg.z}, {b ? e[7] : e[15], b ? e[7:0] == 8'h00 : e[15:0] == 16'h0000})
		`CHK(d_mem, dm != mode_direct)
		`CHK(sp_we, m != mode_direct && m != mode_indirect)
		`CHK(sp_new, sa[15:0])
		`CHK(s_addr, sa[31:16])
		`CHK(d_addr, da[31:16])
		`CHK(dp_we, dm != mode_direct && dm != mode_indirect)
		`CHK(dp_new, da[15:0])
		cexp = e[16];
		@(negedge clk);
		`CHK(valid, 1'b0)
	endtask : run

	task automatic complete_run();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : complete_run

	// ==========================================
	// Sequence
	initial begin
		{nrst, start, pre, pre_c, sptr, sdata, dptr, cexp} = '0;
		cmd = '0;
		num_errors = 0;
		n_tests = 0;
		void'($urandom(32'haffeb966));
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		run(rotate_right_through_carry, 1'b0, mode_post_inc, mode_indirect,
			16'hC041, 16'h2008, 1'b1, 1'b1);
		for (int i = 0; i < 16; i++)
			run(rot_op_e'(i[1:0]), i[2], pick_mode(3'(i)), pick_mode(3'(i + 3)),
				i[3] ? 16'h0000 : 16'h8001, i[0] ? 16'hFFFE : 16'h0001, 1'b1, i[3]);
		for (int i = 0; i < 80; i++)
			run(rot_op_e'(2'($urandom)), 1'($urandom), pick_mode(3'($urandom)),
				pick_mode(3'($urandom)), 16'($urandom), 16'($urandom), 1'($urandom),
				1'($urandom));
		// Mid-run reset: registered outputs clear, core carry restarts at zero
		nrst = 1'b0;
		@(negedge clk);
		`CHK({res, sp_new, dp_new, d_addr}, {4{RESULT_RST}})
		`CHK({flg, valid, d_mem, sp_we, dp_we}, {{3{FLAG_RST}}, 4'h0})
		@(negedge clk);
		nrst = 1'b1;
		cexp = FLAG_RST;
		run(rotate_right_through_carry, 1'b0, mode_direct, mode_direct,
			16'h0001, 16'h0000, 1'b0, 1'b0);
		run(rotate_right_no_carry, 1'b0, mode_indirect, mode_direct,
			16'h0001, 16'h0000, 1'b0, 1'b0);
		complete_run();
	end

	initial begin
		repeat (1000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule : test_rotate_unit
